// ### common/supply_wake_pkg.sv
// Types for the supply/wake status register bank
package supply_wake_pkg;
  typedef logic [15:0] reg_data_t;
  typedef logic [5:0] reg_addr_t;
  typedef enum logic [2:0] {
    MON_EXTERNAL = 3'b000,
    MON_PREREG = 3'b001,
    MON_LINEAR = 3'b010,
    MON_RSVD_3 = 3'b011,
    MON_RSVD_4 = 3'b100,
    MON_SECOND_BUCK = 3'b101,
    MON_EXT_6 = 3'b110,
    MON_EXT_7 = 3'b111
  } monitor_src_e;
endpackage

// ### common/supply_wake_regs.svh
// Register offsets, field positions and reset values for the supply/wake status bank
`ifndef SUPPLY_WAKE_REGS_SVH
`define SUPPLY_WAKE_REGS_SVH
// ==========================================================
// Register addresses (bank-local, no offsets documented)
`define SW_ADDR_STATUS 6'h00
`define SW_ADDR_MONSEL 6'h01
`define SW_ADDR_SVS 6'h02
// ==========================================================
// Status register fields (bits 23..8 of frame map to data[15:0])
`define SW_BIT_FB_OV 15
`define SW_BIT_UV7 14
`define SW_BIT_CORE_ST 12
`define SW_BIT_SECOND_ST 10
`define SW_BIT_LIN_ST 9
`define SW_BIT_PREUVL 7
`define SW_BIT_PREUVH 6
`define SW_BIT_SUPUVL 5
`define SW_BIT_SUPUVH 4
`define SW_BIT_WKB_LVL 3
`define SW_BIT_WKA_LVL 2
`define SW_BIT_WKB_FLG 1
`define SW_BIT_WKA_FLG 0
// ==========================================================
// Field positions in the other two registers
`define SW_MONSEL_LSB 0
`define SW_SVS_LSB 0
// ==========================================================
// Reset values and the scaling offset saturation limit
`define SW_FLAGS_RST 8'h00
`define SW_MONSEL_RST 3'h0
`define SW_SVS_RST 5'h00
`define SW_SVS_MAX 5'h10
`endif

// ### logic/supply_wake_status_regs.sv
// Supply event flags, wake status, monitor source select and scaling offset
`timescale 1ns/1ps
`include "supply_wake_regs.svh"
// ==========================================================
module supply_wake_status_regs (
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CLK_EN,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire supply_wake_pkg::reg_addr_t REG_ADDR,
  input wire supply_wake_pkg::reg_data_t REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic [5:0] SUPPLY_EVENT,
  input wire logic [2:0] REG_ON,
  input wire logic WAKE_A_PIN,
  input wire logic WAKE_B_PIN,
  input wire logic WAKE_A_SOURCE,
  input wire logic WAKE_B_SOURCE,
  input wire logic [4:0] SVS_OFFSET_IN,
  output logic [2:0] MONITOR_ONE_SOURCE
);
  import supply_wake_pkg::*;

  // ==========================================================
  // Pin synchronisers: wake pins and regulator states are analog-side
  // Live bits lag the pins by two cycles; a pulse shorter than a cycle
  // may never be seen, which is acceptable for slow level information
  logic [4:0] sync1_q;
  logic [4:0] sync2_q;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      sync1_q <= 5'h00;
      sync2_q <= 5'h00;
    end else if (CLK_EN) begin
      sync1_q <= {WAKE_B_PIN, WAKE_A_PIN, REG_ON};
      sync2_q <= sync1_q;
    end
  end
  wire logic [2:0] reg_on_live = sync2_q[2:0];
  wire logic wake_a_level = sync2_q[3];
  wire logic wake_b_level = sync2_q[4];

  // ==========================================================
  // Decode
  wire logic sel_status = (REG_ADDR == `SW_ADDR_STATUS);
  wire logic sel_monsel = (REG_ADDR == `SW_ADDR_MONSEL);
  wire logic sel_svs = (REG_ADDR == `SW_ADDR_SVS);
  wire logic wr_status = CLK_EN && REG_WR && sel_status;
  wire logic wr_monsel = CLK_EN && REG_WR && sel_monsel;

  // ==========================================================
  // Latched flags: order fb_ov, uv7, preuvl, preuvh, supuvl, supuvh, wkb, wka
  wire logic [7:0] flag_set = {SUPPLY_EVENT, WAKE_B_SOURCE, WAKE_A_SOURCE};
  wire logic [7:0] flag_wdata = {REG_WDATA[`SW_BIT_FB_OV], REG_WDATA[`SW_BIT_UV7],
                                 REG_WDATA[`SW_BIT_PREUVL:`SW_BIT_SUPUVH],
                                 REG_WDATA[`SW_BIT_WKB_FLG], REG_WDATA[`SW_BIT_WKA_FLG]};
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_flag
      // Set wins over a simultaneous clear so no event is lost
      assign flags_d[gi] = flag_set[gi] ||
                           (flags_q[gi] && !(wr_status && flag_wdata[gi]));
    end
  endgenerate
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      flags_q <= `SW_FLAGS_RST;
    end else if (CLK_EN) begin
      flags_q <= flags_d;
    end
  end

  // ==========================================================
  // Monitor source select and scaling offset
  logic [2:0] monsel_q;
  logic [4:0] svs_q;
  // Offset beyond the documented range saturates at the largest code
  wire logic [4:0] svs_d = (SVS_OFFSET_IN > `SW_SVS_MAX) ? `SW_SVS_MAX : SVS_OFFSET_IN;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      monsel_q <= `SW_MONSEL_RST;
      svs_q <= `SW_SVS_RST;
    end else if (CLK_EN) begin
      if (wr_monsel) begin
        monsel_q <= REG_WDATA[`SW_MONSEL_LSB +: 3];
      end
      svs_q <= svs_d;
    end
  end

  // ==========================================================
  // Read data
  logic [15:0] status_word;
  always_comb begin
    status_word = 16'h0000;
    status_word[`SW_BIT_FB_OV] = flags_q[7];
    status_word[`SW_BIT_UV7] = flags_q[6];
    status_word[`SW_BIT_PREUVL:`SW_BIT_SUPUVH] = flags_q[5:2];
    status_word[`SW_BIT_CORE_ST] = reg_on_live[2];
    status_word[`SW_BIT_SECOND_ST] = reg_on_live[1];
    status_word[`SW_BIT_LIN_ST] = reg_on_live[0];
    status_word[`SW_BIT_WKB_LVL] = wake_b_level;
    status_word[`SW_BIT_WKA_LVL] = wake_a_level;
    status_word[`SW_BIT_WKB_FLG] = flags_q[1];
    status_word[`SW_BIT_WKA_FLG] = flags_q[0];
  end
  wire logic [15:0] rd_mux = sel_status ? status_word :
                             sel_monsel ? {13'h0000, monsel_q} :
                             sel_svs ? {11'h000, svs_q} : 16'h0000;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= 16'h0000;
      REG_RVALID <= 1'b0;
      MONITOR_ONE_SOURCE <= `SW_MONSEL_RST;
    end else if (CLK_EN) begin
      REG_RVALID <= REG_RD;
      if (REG_RD) begin
        REG_RDATA <= rd_mux;
      end
      MONITOR_ONE_SOURCE <= monsel_q;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  flag_sets_a: assert property (CLK_EN && SUPPLY_EVENT[5] |=> flags_q[7])
    else $error("overvoltage flag not set");
  flag_clear_a: assert property (
    CLK_EN && wr_status && REG_WDATA[`SW_BIT_UV7] && !SUPPLY_EVENT[4] |=> !flags_q[6])
    else $error("write one did not clear flag");
  set_wins_a: assert property (
    CLK_EN && wr_status && REG_WDATA[`SW_BIT_UV7] && SUPPLY_EVENT[4] |=> flags_q[6])
    else $error("clear beat a simultaneous event");
  state_live_a: assert property (
    CLK_EN && $past(CLK_EN) && REG_RD && sel_status
    |=> REG_RDATA[`SW_BIT_CORE_ST] == $past(sync2_q[2]))
    else $error("core state bit wrong");
  second_live_a: assert property (
    CLK_EN && REG_RD && sel_status |=> REG_RDATA[`SW_BIT_SECOND_ST] == $past(sync2_q[1]))
    else $error("second buck state bit wrong");
  linear_live_a: assert property (
    CLK_EN && REG_RD && sel_status |=> REG_RDATA[`SW_BIT_LIN_ST] == $past(sync2_q[0]))
    else $error("linear regulator state bit wrong");
  wake_b_lvl_a: assert property (CLK_EN && REG_RD && sel_status
    |=> REG_RDATA[`SW_BIT_WKB_LVL] == $past(wake_b_level))
    else $error("wake b level wrong");
  wake_a_lvl_a: assert property (CLK_EN && REG_RD && sel_status
    |=> REG_RDATA[`SW_BIT_WKA_LVL] == $past(wake_a_level))
    else $error("wake a level wrong");
  wake_b_flag_a: assert property (CLK_EN && WAKE_B_SOURCE |=> flags_q[1])
    else $error("wake b flag not latched");
  wake_a_flag_a: assert property (CLK_EN && WAKE_A_SOURCE |=> flags_q[0])
    else $error("wake a flag not latched");
  wake_b_clr_a: assert property (
    wr_status && REG_WDATA[`SW_BIT_WKB_FLG] && !WAKE_B_SOURCE |=> !flags_q[1])
    else $error("wake b flag not cleared");
  wake_a_clr_a: assert property (
    wr_status && REG_WDATA[`SW_BIT_WKA_FLG] && !WAKE_A_SOURCE |=> !flags_q[0])
    else $error("wake a flag not cleared");
  monsel_write_a: assert property (
    wr_monsel |=> ##1 MONITOR_ONE_SOURCE == $past(REG_WDATA[2:0], 2))
    else $error("monitor source not taken");
  monsel_hold_a: assert property (
    CLK_EN && !wr_monsel |=> monsel_q == $past(monsel_q))
    else $error("monitor source changed without write");
  svs_range_a: assert property (svs_q <= `SW_SVS_MAX)
    else $error("scaling offset out of range");
  svs_follow_a: assert property (
    CLK_EN && (SVS_OFFSET_IN <= `SW_SVS_MAX) |=> svs_q == $past(SVS_OFFSET_IN))
    else $error("scaling offset not mirrored");
  svs_read_a: assert property (
    CLK_EN && REG_RD && sel_svs |=> REG_RDATA == {11'h000, $past(svs_q)})
    else $error("scaling offset read wrong");
  flag_hold_a: assert property (
    CLK_EN && flags_q[4] && !(wr_status && REG_WDATA[`SW_BIT_PREUVH]) |=> flags_q[4])
    else $error("flag dropped without clear");
  wake_hold_a: assert property (
    CLK_EN && flags_q[1] && !(wr_status && REG_WDATA[`SW_BIT_WKB_FLG]) |=> flags_q[1])
    else $error("wake flag dropped without clear");
  // Freeze must hold every latched flag, otherwise events leak past a gated clock
  freeze_a: assert property (!CLK_EN |=> flags_q == $past(flags_q))
    else $error("flags moved while frozen");
  rvalid_pulse_a: assert property (CLK_EN && REG_RD |=> REG_RVALID)
    else $error("read not answered");

  // ==========================================================
  // Coverage of the main scenarios

  flag_cleared_c: cover property (wr_status && flags_q[7] ##1 !flags_q[7]);
  wake_seen_c: cover property (WAKE_A_SOURCE ##1 flags_q[0]);
  monsel_sec_c: cover property (MONITOR_ONE_SOURCE == MON_SECOND_BUCK);
  set_clear_c: cover property (wr_status && REG_WDATA[0] && WAKE_A_SOURCE);
  frozen_event_c: cover property (!CLK_EN && SUPPLY_EVENT[5]);
endmodule

// ### tb/host_model.sv
// Host model: issues one register strobe per call
`timescale 1ns/1ps
module host_model (
  input wire logic clk,
  output logic wr = 1'b0,
  output logic rd = 1'b0,
  output logic [5:0] addr = 6'h00,
  output logic [15:0] wdata = 16'h0000
);
  // Strobe stands one cycle; released lines scrambled so stale values never pass
  task automatic req(input logic w, input logic [5:0] a, input logic [15:0] d);
    @(negedge clk);
    wr = w;
    rd = !w;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
    addr = ~a;
    wdata = ~d;
  endtask
endmodule

// ### tb/supply_wake_status_regs_bench.sv
// Self-checking bench for the supply/wake status register bank
`timescale 1ns/1ps
`include "supply_wake_regs.svh"
module supply_wake_status_regs_bench;
  import supply_wake_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, wr, rd, rvalid, wa = 1'b0, wb = 1'b0, sa = 1'b0, sb = 1'b0;
  logic en = 1'b1;
  logic [5:0] addr, ev = 6'h00;
  logic [15:0] wdata, rdata;
  logic [2:0] on = 3'h0, mon;
  logic [4:0] svs = 5'h00;
  logic [31:0] seed = 32'hbb788a57;
  int miscompares = 0, checks_done = 0;
  reg_data_t exp_q[$];
  always #12.5 clk = ~clk;
  host_model i_host (.clk(clk), .wr(wr), .rd(rd), .addr(addr), .wdata(wdata));
  supply_wake_status_regs i_dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(en), .REG_WR(wr),
    .REG_RD(rd), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .SUPPLY_EVENT(ev), .REG_ON(on), .WAKE_A_PIN(wa), .WAKE_B_PIN(wb), .WAKE_A_SOURCE(sa),
    .WAKE_B_SOURCE(sb), .SVS_OFFSET_IN(svs), .MONITOR_ONE_SOURCE(mon));
  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input reg_data_t seen, input reg_data_t exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rd_exp(input logic [5:0] a, input reg_data_t e);
    exp_q.push_back(e);
    i_host.req(1'b0, a, 16'h0000);
  endtask
  task automatic give_verdict();
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(negedge clk) if (rvalid === 1'b1) check(rdata, exp_q.pop_front());
  initial begin
    #200us;
    miscompares++;
    give_verdict();
  end
  // ==========================================================
  // Scenarios
  initial begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rd_exp(`SW_ADDR_STATUS, 16'h0000);
    rd_exp(`SW_ADDR_MONSEL, 16'h0000);
    // Event while frozen must not latch
    en = 1'b0;
    ev = 6'h20;
    @(negedge clk);
    ev = 6'h00;
    en = 1'b1;
    rd_exp(`SW_ADDR_STATUS, 16'h0000);
    ev = 6'h3f;
    sa = 1'b1;
    sb = 1'b1;
    @(negedge clk);
    ev = 6'h00;
    sa = 1'b0;
    sb = 1'b0;
    rd_exp(`SW_ADDR_STATUS, 16'hc0f3);
    i_host.req(1'b1, `SW_ADDR_STATUS, 16'h0000);
    rd_exp(`SW_ADDR_STATUS, 16'hc0f3);
    i_host.req(1'b1, `SW_ADDR_STATUS, 16'h8001);
    rd_exp(`SW_ADDR_STATUS, 16'h40f2);
    // Event in the same cycle as its write-one clear: the event wins
    fork
      i_host.req(1'b1, `SW_ADDR_STATUS, 16'h4000);
      begin
        @(negedge clk);
        ev = 6'h10;
        @(negedge clk);
        ev = 6'h00;
      end
    join
    rd_exp(`SW_ADDR_STATUS, 16'h40f2);
    i_host.req(1'b1, `SW_ADDR_STATUS, 16'h40f2);
    rd_exp(`SW_ADDR_STATUS, 16'h0000);
    // Live levels pass two flops, so settle three cycles first
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      on = seed[2:0];
      wa = seed[3];
      wb = seed[4];
      repeat (3) @(negedge clk);
      rd_exp(`SW_ADDR_STATUS, {3'h0, on[2], 1'b0, on[1:0], 5'h00, wb, wa, 2'h0});
      i_host.req(1'b1, `SW_ADDR_MONSEL, {13'h0000, 3'(i)});
      rd_exp(`SW_ADDR_MONSEL, {13'h0000, 3'(i)});
      check({13'h0000, mon}, {13'h0000, 3'(i)});
    end
    // Read-only offset ignores writes and saturates above the top code
    for (int c = 0; c < 20; c++) begin
      svs = 5'(c);
      i_host.req(1'b1, `SW_ADDR_SVS, 16'h001f);
      rd_exp(`SW_ADDR_SVS, {11'h000, (c > 16) ? `SW_SVS_MAX : 5'(c)});
    end
    rd_exp(6'h3f, 16'h0000);
    repeat (4) @(negedge clk);
    check(16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule
